/* File: rtl/ubc_baud_gen.sv */
// Purpose: baud divider giving oversample ticks and transmit bit ticks
// Assumes: divisor and ratio held steady while running
// Notes: zero divisor or stopped generator gives no ticks
`timescale 1ns/1ps
module ubc_baud_gen #(
  parameter int DIV_W = ubc_pkg::DIV_W,
  parameter int OSR_W = ubc_pkg::OSR_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Settings
  input wire logic run,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic [OSR_W-1:0] oversample_ratio,
  // Ticks
  output logic os_tick,
  output logic bit_tick
);
  logic [DIV_W-1:0] div_cnt_q;
  logic [OSR_W-1:0] os_cnt_q;
  logic active;

  // Generator runs only when enabled and divisor nonzero
  assign active = run && (divisor != '0);
  assign os_tick = active && (div_cnt_q >= divisor - 1'b1);
  assign bit_tick = os_tick && (os_cnt_q >= oversample_ratio);

  // Divide the clock by the divisor
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_q <= '0;
    end else if (!active || os_tick) begin // R3 R18
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  // Divide oversample ticks by ratio plus one
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      os_cnt_q <= '0;
    end else if (!active || bit_tick) begin // R3
      os_cnt_q <= '0;
    end else if (os_tick) begin
      os_cnt_q <= os_cnt_q + 1'b1;
    end
  end

  // Tick spacing and stopped generator
  tick_space_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
    os_tick && $stable(divisor) && divisor > 1 |=> !os_tick)
    else $error("oversample ticks too close");
  zero_div_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R18
    divisor == '0 |-> !os_tick && !bit_tick)
    else $error("tick with zero divisor");
endmodule

/* File: rtl/ubc_pkg.sv */
// Purpose: shared constants of the serial baud and frame configuration block
// Assumes: 32-bit register words, register index times four is byte address
// Notes: frame bit positions apply to the frame control register
package ubc_pkg;
  // Bus geometry
  localparam int ADDR_W = 6;
  localparam int IDX_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Register indices (byte address is index times four)
  localparam logic [IDX_W-1:0] IDX_BAUD_HIGH = 4'h0;
  localparam logic [IDX_W-1:0] IDX_BAUD_LOW = 4'h1;
  localparam logic [IDX_W-1:0] IDX_FRAME = 4'h2;
  localparam logic [IDX_W-1:0] IDX_CTRL = 4'h3;
  localparam logic [IDX_W-1:0] IDX_STATUS = 4'h4;
  localparam logic [IDX_W-1:0] IDX_DATA = 4'h7;
  // Divisor and oversampling
  localparam int DIV_W = 13;
  localparam int DIV_HI_W = 5;
  localparam int OSR_W = 5;
  localparam logic [7:0] BAUD_LOW_RESET = 8'h04;
  localparam logic [OSR_W-1:0] OSR_RESET = 5'h0F;
  // Frame control fields
  localparam int FC_LOOP = 7;
  localparam int FC_HALT = 6;
  localparam int FC_RX_SOURCE_SELECT = 5;
  localparam int FC_NINE = 4;
  localparam int FC_WAKE = 3;
  localparam int FC_ILT = 2;
  localparam int FC_PAR_ON = 1;
  localparam int FC_PAR_ODD = 0;
  // Control fields
  localparam int CT_DIR = 5;
  localparam int CT_TX_ON = 3;
  localparam int CT_RX_ON = 2;
  localparam int CT_STANDBY = 1;
  // Status fields
  localparam int ST_RUN = 0;
  localparam int ST_TX_BUSY = 1;
  localparam int ST_TX_FULL = 2;
  localparam int ST_RX_FULL = 3;
  localparam int ST_PAR_ERR = 4;
  localparam int ST_FRM_ERR = 5;
  localparam int ST_IDLE = 6;
  // Character geometry
  localparam logic [3:0] CHAR_LEN_8 = 4'h8;
  localparam logic [3:0] CHAR_LEN_9 = 4'h9;
  localparam logic [3:0] FRAME_EXTRA = 4'h2;
  localparam int FRAME_W = 12;
  localparam int RX_W = 11;
endpackage

/* File: rtl/ubc_uart_core.sv */
// Purpose: baud and frame configuration with a small serial transceiver
// Assumes: AXI4-Lite register access, registers of up to 9 bits in low word bits
// Notes: pins pass a three-flop filter before use
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// R1: 13-bit divisor in two registers, writable only while rx and tx off.
// R2: Low divisor resets nonzero; generator idle until rx or tx enabled.
// R3: Bit rate is baud clock over divisor times ratio plus one.
// R4: Software should change frame control only with rx and tx off.
// R5: Loop bit clear gives full duplex on separate rx and tx pins.
// R6: Loop bit set routes transmitter to receiver, rx pin ignored.
// R7: Source select matters only in loop mode; receiver reads tx node.
// R8: Loop set, source clear gives internal loopback without rx pin.
// R9: Loop and source set give single-wire use of the tx pin.
// R10: Halt bit keeps block running in wait when 0, stops it when 1; code only blocks starting new characters in wait, generator keeps running.
// R11: Length bit picks 8-bit or 9-bit characters for both directions.
// R12: Wakeup bit picks idle-line or address-mark wakeup for standby.
// R13: Idle needs line high; count after start or after stop bit.
// R14: Parity enable generates and checks parity before the stop bit.
// R15: Parity type picks even or odd over character plus parity.
// R16: In single-wire mode direction bit decides drive or release of pin.
// R17: Clearing tx enable keeps pin driven until pending character ends.
// R18: Zero divisor stops the baud generator entirely.
module ubc_uart_core #(
  parameter int DIV_W = ubc_pkg::DIV_W,
  parameter int OSR_W = ubc_pkg::OSR_W,
  parameter logic [OSR_W-1:0] OVERSAMPLE_RATIO = ubc_pkg::OSR_RESET
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // AXI4-Lite write
  input wire logic [ubc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ubc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Power mode
  input wire logic wait_mode,
  // Serial pins
  input wire logic rx_pin,
  input wire logic tx_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe
);
  typedef enum logic [1:0] {
    UBC_RX_IDLE = 2'b00,
    UBC_RX_START = 2'b01,
    UBC_RX_BITS = 2'b10
  } ubc_rx_e;

  logic aw_q, w_q, bvalid_q, rvalid_q;
  logic [ubc_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q, rd_word;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_go, wr_en, wr_ok, rd_go, rd_ok, lock;
  logic [ubc_pkg::IDX_W-1:0] wr_idx, rd_idx;
  logic [ubc_pkg::DIV_HI_W-1:0] div_hi_q;
  logic [7:0] div_lo_q, fc_q;
  logic tx_on_q, rx_on_q, dir_q, standby_q, baud_run_q;
  logic os_tick, bit_tick, halted, internal_loopback, single;
  logic [1:0] s1_q, s2_q, s3_q, filt_q;
  logic rx_line;
  logic [8:0] tx_buf_q, tx_data, rx_data_q, rx_data;
  logic tx_full_q, tx_busy_q, tx_serial_q, tx_drive_q, tx_load, tx_par;
  logic [ubc_pkg::FRAME_W-1:0] tx_sr_q;
  logic [3:0] tx_cnt_q, dlen, tx_len, rx_last, idle_need;
  ubc_rx_e rx_st_q;
  logic [OSR_W-1:0] rx_os_q, idle_os_q;
  logic [3:0] bit_idx_q, idle_cnt_q;
  logic [ubc_pkg::RX_W-1:0] rx_sr_q;
  logic char_done_q, par_bad, rx_full_q, par_err_q, frm_err_q, idle_q;
  logic idle_evt, idle_armed_q, wake_evt, accept, rx_msb;

  // Write channel handshakes, either order
  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wr_go = aw_q && w_q && !bvalid_q;
  assign wr_idx = aw_addr_q[ubc_pkg::ADDR_W-1:2];
  assign wr_ok = (aw_addr_q[1:0] == 2'b00) && (wr_idx <= ubc_pkg::IDX_STATUS
    || wr_idx == ubc_pkg::IDX_DATA);
  assign wr_en = wr_go && wr_ok && w_strb_q[0];

  // Capture address and data, then answer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= ubc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? ubc_pkg::RESP_OKAY : ubc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rd_go = s_axi_arvalid && !rvalid_q;
  assign rd_idx = s_axi_araddr[ubc_pkg::ADDR_W-1:2];

  // Read word selection
  always_comb begin
    rd_word = '0;
    rd_ok = (s_axi_araddr[1:0] == 2'b00);
    unique case (rd_idx)
      ubc_pkg::IDX_BAUD_HIGH: rd_word[ubc_pkg::DIV_HI_W-1:0] = div_hi_q;
      ubc_pkg::IDX_BAUD_LOW: rd_word[7:0] = div_lo_q;
      ubc_pkg::IDX_FRAME: rd_word[7:0] = fc_q;
      ubc_pkg::IDX_CTRL: begin
        rd_word[ubc_pkg::CT_DIR] = dir_q;
        rd_word[ubc_pkg::CT_TX_ON] = tx_on_q;
        rd_word[ubc_pkg::CT_RX_ON] = rx_on_q;
        rd_word[ubc_pkg::CT_STANDBY] = standby_q;
      end
      ubc_pkg::IDX_STATUS: begin
        rd_word[ubc_pkg::ST_RUN] = baud_run_q;
        rd_word[ubc_pkg::ST_TX_BUSY] = tx_busy_q;
        rd_word[ubc_pkg::ST_TX_FULL] = tx_full_q;
        rd_word[ubc_pkg::ST_RX_FULL] = rx_full_q;
        rd_word[ubc_pkg::ST_PAR_ERR] = par_err_q;
        rd_word[ubc_pkg::ST_FRM_ERR] = frm_err_q;
        rd_word[ubc_pkg::ST_IDLE] = idle_q;
      end
      ubc_pkg::IDX_DATA: rd_word[8:0] = rx_data_q;
      default: rd_ok = 1'b0;
    endcase
  end

  // Registered read answer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= ubc_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_ok ? rd_word : '0;
      rresp_q <= rd_ok ? ubc_pkg::RESP_OKAY : ubc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Divisor registers, locked while either direction is on
  assign lock = tx_on_q || rx_on_q;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_hi_q <= '0;
      div_lo_q <= ubc_pkg::BAUD_LOW_RESET;
    end else if (wr_en && !lock) begin // R1
      if (wr_idx == ubc_pkg::IDX_BAUD_HIGH)
        div_hi_q <= w_data_q[ubc_pkg::DIV_HI_W-1:0];
      if (wr_idx == ubc_pkg::IDX_BAUD_LOW)
        div_lo_q <= w_data_q[7:0];
    end
  end

  // Frame control, accepted at any time
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fc_q <= '0;
    end else if (wr_en && wr_idx == ubc_pkg::IDX_FRAME) begin // R4
      fc_q <= w_data_q[7:0];
    end
  end

  // Control bits and generator start latch
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_on_q <= 1'b0;
      rx_on_q <= 1'b0;
      dir_q <= 1'b0;
      standby_q <= 1'b0;
      baud_run_q <= 1'b0;
    end else if (wr_en && wr_idx == ubc_pkg::IDX_CTRL) begin
      tx_on_q <= w_data_q[ubc_pkg::CT_TX_ON];
      rx_on_q <= w_data_q[ubc_pkg::CT_RX_ON];
      dir_q <= w_data_q[ubc_pkg::CT_DIR];
      standby_q <= w_data_q[ubc_pkg::CT_STANDBY];
      if (w_data_q[ubc_pkg::CT_TX_ON] || w_data_q[ubc_pkg::CT_RX_ON])
        baud_run_q <= 1'b1; // R2
    end else if (wake_evt) begin // R12
      standby_q <= 1'b0;
    end
  end

  // Baud generator
  ubc_baud_gen #(.DIV_W(DIV_W), .OSR_W(OSR_W)) u_baud (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(baud_run_q),
    .divisor({div_hi_q, div_lo_q}),
    .oversample_ratio(OVERSAMPLE_RATIO),
    .os_tick(os_tick),
    .bit_tick(bit_tick)
  );

  // Pin filter: change taken when second and third stages agree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      filt_q <= '1;
    end else begin
      s1_q <= {tx_pin_in, rx_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
    end
  end

  // Receiver source routing
  assign internal_loopback = fc_q[ubc_pkg::FC_LOOP];
  assign single = internal_loopback && fc_q[ubc_pkg::FC_RX_SOURCE_SELECT]; // R7
  assign rx_line = !internal_loopback ? filt_q[0] // R5
    : (single ? filt_q[1] : tx_serial_q); // R6 R8 R9
  assign halted = fc_q[ubc_pkg::FC_HALT] && wait_mode; // R10

  // Pin drive, direction bit in single-wire mode
  assign tx_pin_out = tx_serial_q;
  assign tx_pin_oe = tx_drive_q && (!single || dir_q); // R16

  // Transmit frame assembly
  assign dlen = fc_q[ubc_pkg::FC_NINE] ? ubc_pkg::CHAR_LEN_9
    : ubc_pkg::CHAR_LEN_8; // R11
  assign tx_data = fc_q[ubc_pkg::FC_NINE] ? tx_buf_q : {1'b0, tx_buf_q[7:0]};
  assign tx_par = (^tx_data) ^ fc_q[ubc_pkg::FC_PAR_ODD]; // R15
  assign tx_len = dlen + ubc_pkg::FRAME_EXTRA + {3'b000, fc_q[ubc_pkg::FC_PAR_ON]};
  assign tx_load = bit_tick && !tx_busy_q && tx_full_q && tx_on_q && !halted;

  // Transmit buffer, write wins over consume
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_buf_q <= '0;
      tx_full_q <= 1'b0;
    end else if (wr_en && wr_idx == ubc_pkg::IDX_DATA) begin
      tx_buf_q <= w_data_q[8:0];
      tx_full_q <= 1'b1;
    end else if (tx_load) begin
      tx_full_q <= 1'b0;
    end
  end

  // Transmit shifter
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_sr_q <= '1;
      tx_cnt_q <= '0;
      tx_busy_q <= 1'b0;
      tx_serial_q <= 1'b1;
      tx_drive_q <= 1'b0;
    end else begin
      tx_drive_q <= tx_on_q || tx_busy_q; // R17
      if (tx_load) begin
        tx_busy_q <= 1'b1;
        tx_cnt_q <= tx_len;
        if (fc_q[ubc_pkg::FC_NINE])
          tx_sr_q <= {1'b1, fc_q[ubc_pkg::FC_PAR_ON] ? tx_par : 1'b1,
            tx_buf_q, 1'b0}; // R14
        else
          tx_sr_q <= {2'b11, fc_q[ubc_pkg::FC_PAR_ON] ? tx_par : 1'b1,
            tx_buf_q[7:0], 1'b0}; // R14
      end else if (bit_tick && tx_busy_q) begin
        if (tx_cnt_q == '0) begin
          tx_busy_q <= 1'b0;
        end else begin
          tx_serial_q <= tx_sr_q[0];
          tx_sr_q <= {1'b1, tx_sr_q[ubc_pkg::FRAME_W-1:1]};
          tx_cnt_q <= tx_cnt_q - 1'b1;
        end
      end
    end
  end

  // Receive state machine on oversample ticks
  assign rx_last = dlen + {3'b000, fc_q[ubc_pkg::FC_PAR_ON]};
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_q <= UBC_RX_IDLE;
      rx_os_q <= '0;
      bit_idx_q <= '0;
      rx_sr_q <= '0;
      char_done_q <= 1'b0;
    end else begin
      char_done_q <= 1'b0;
      if (os_tick) begin
        unique case (rx_st_q)
          UBC_RX_IDLE: begin
            rx_os_q <= '0;
            if (rx_on_q && !halted && !rx_line)
              rx_st_q <= UBC_RX_START;
          end
          UBC_RX_START: begin
            if (rx_os_q == (OVERSAMPLE_RATIO >> 1)) begin
              rx_os_q <= '0;
              bit_idx_q <= '0;
              rx_st_q <= rx_line ? UBC_RX_IDLE : UBC_RX_BITS;
            end else begin
              rx_os_q <= rx_os_q + 1'b1;
            end
          end
          UBC_RX_BITS: begin
            if (rx_os_q == OVERSAMPLE_RATIO) begin
              rx_os_q <= '0;
              rx_sr_q[bit_idx_q] <= rx_line;
              bit_idx_q <= bit_idx_q + 1'b1;
              if (bit_idx_q == rx_last) begin // R11
                rx_st_q <= UBC_RX_IDLE;
                char_done_q <= 1'b1;
              end
            end else begin
              rx_os_q <= rx_os_q + 1'b1;
            end
          end
          default: rx_st_q <= UBC_RX_IDLE;
        endcase
      end
    end
  end

  // Received character checks
  assign rx_data = fc_q[ubc_pkg::FC_NINE] ? rx_sr_q[8:0]
    : {1'b0, rx_sr_q[7:0]};
  assign par_bad = fc_q[ubc_pkg::FC_PAR_ON] && ((^rx_sr_q[rx_last - 1'b1 -: 1]
    ^ ^rx_data) != fc_q[ubc_pkg::FC_PAR_ODD]); // R14 R15
  assign rx_msb = fc_q[ubc_pkg::FC_NINE] ? rx_data[8] : rx_data[7];
  assign wake_evt = standby_q && ((char_done_q && fc_q[ubc_pkg::FC_WAKE]
    && rx_msb) || (idle_evt && !fc_q[ubc_pkg::FC_WAKE])); // R12
  assign accept = char_done_q && (!standby_q || wake_evt);

  // Receive data and sticky flags, set wins over clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_data_q <= '0;
      rx_full_q <= 1'b0;
      par_err_q <= 1'b0;
      frm_err_q <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      if (accept) begin
        rx_data_q <= rx_data;
        rx_full_q <= 1'b1;
      end else if (rd_go && rd_idx == ubc_pkg::IDX_DATA) begin
        rx_full_q <= 1'b0;
      end
      if (accept && par_bad)
        par_err_q <= 1'b1;
      else if (wr_en && wr_idx == ubc_pkg::IDX_STATUS
               && w_data_q[ubc_pkg::ST_PAR_ERR])
        par_err_q <= 1'b0;
      if (accept && !rx_sr_q[rx_last])
        frm_err_q <= 1'b1;
      else if (wr_en && wr_idx == ubc_pkg::IDX_STATUS
               && w_data_q[ubc_pkg::ST_FRM_ERR])
        frm_err_q <= 1'b0;
      if (idle_evt)
        idle_q <= 1'b1;
      else if (wr_en && wr_idx == ubc_pkg::IDX_STATUS
               && w_data_q[ubc_pkg::ST_IDLE])
        idle_q <= 1'b0;
    end
  end

  // Idle line detector counting high bit times
  assign idle_need = rx_last + ubc_pkg::FRAME_EXTRA - 1'b1; // R13
  assign idle_evt = idle_armed_q && os_tick && idle_os_q == OVERSAMPLE_RATIO
    && rx_line && idle_cnt_q == idle_need - 1'b1;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_os_q <= '0;
      idle_cnt_q <= '0;
      idle_armed_q <= 1'b0;
    end else begin
      if (char_done_q)
        idle_armed_q <= 1'b1;
      else if (idle_evt)
        idle_armed_q <= 1'b0;
      if (os_tick)
        idle_os_q <= (idle_os_q == OVERSAMPLE_RATIO) ? '0 : idle_os_q + 1'b1;
      if (!rx_line || !rx_on_q || (fc_q[ubc_pkg::FC_ILT]
          && rx_st_q != UBC_RX_IDLE)) begin // R13
        idle_cnt_q <= '0;
      end else if (os_tick && idle_os_q == OVERSAMPLE_RATIO && idle_cnt_q < idle_need) begin
        idle_cnt_q <= idle_cnt_q + 1'b1;
      end
    end
  end

  // Checks on configuration effects
  div_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
    lock |=> $stable({div_hi_q, div_lo_q}))
    else $error("divisor changed while enabled");
  gen_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
    !baud_run_q |-> !os_tick)
    else $error("baud tick before enable");
  full_duplex_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
    !internal_loopback && tx_on_q |=> tx_drive_q && tx_pin_oe)
    else $error("tx pin not driven in normal mode");
  int_loop_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R8
    internal_loopback && !single |-> rx_line == tx_serial_q)
    else $error("loopback receiver not on transmitter");
  wire_dir_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R16
    single && !dir_q |-> !tx_pin_oe)
    else $error("single-wire pin driven while receiving");
  tx_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R17
    tx_busy_q ##1 tx_busy_q |-> tx_drive_q)
    else $error("pin released during character");
  wait_halt_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R10
    halted |-> !tx_load ##1 rx_st_q != UBC_RX_START || $past(rx_st_q) != UBC_RX_IDLE)
    else $error("new character started while halted");
  tx_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R11
    tx_load |=> tx_cnt_q == $past(tx_len) && tx_busy_q)
    else $error("wrong frame length");
  tx_par_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R15
    tx_load && fc_q[ubc_pkg::FC_PAR_ON] && !fc_q[ubc_pkg::FC_NINE]
    |=> (^tx_sr_q[9:1]) == $past(fc_q[ubc_pkg::FC_PAR_ODD]))
    else $error("transmit parity wrong");
  cover_single_c: cover property (@(posedge ref_clk) single && tx_pin_oe);
  cover_loop_c: cover property (@(posedge ref_clk) internal_loopback && char_done_q);
  cover_idle_c: cover property (@(posedge ref_clk) idle_evt);
  cover_perr_c: cover property (@(posedge ref_clk) accept && par_bad);
endmodule

/* File: tb/uart_baud_and_frame_config_tb_top.sv */
// Purpose: self-checking bench for the baud and frame configuration block
// Assumes: divisor 1 gives 16 clocks per bit
// Notes: each test task judges its own results
`timescale 1ns/1ps
`define chk(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module uart_baud_and_frame_config_tb_top;
  // Bench state
  logic ref_clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, wait_mode = 0, rx_gate = 1, bad;
  logic awready, wready, bvalid, arready, rvalid, txo, txe, rxl;
  logic [5:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp;
  logic [10:0] cap;
  int errors = 0, checks_done = 0;
  // Shared tx node, driven by the remote rx line when released
  wire logic node = txe ? txo : rxl;

  // Clock
  always #50 ref_clk = ~ref_clk;

  // Block and far side
  ubc_uart_core dut (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .wait_mode(wait_mode), .rx_pin(rxl & rx_gate),
    .tx_pin_in(node), .tx_pin_out(txo), .tx_pin_oe(txe));
  ubc_remote u_remote (.ref_clk(ref_clk), .tx_line(node), .rx_line(rxl));

  // Register write, address and data offered together
  task automatic wr(input logic [5:0] a, input logic [8:0] v);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {23'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      @(posedge ref_clk iff awready) awvalid <= 1'b0;
      @(posedge ref_clk iff wready) wvalid <= 1'b0;
    join
    @(posedge ref_clk iff bvalid) bready <= 1'b0;
  endtask

  // Register read with expected data and response
  task automatic rd(input logic [5:0] a, input logic [8:0] e,
                    input logic [1:0] er);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge ref_clk iff arready) arvalid <= 1'b0;
    @(posedge ref_clk iff rvalid) rready <= 1'b0;
    `chk(rdata, {23'h0, e})
    `chk(rresp, er)
  endtask

  // Send one character and compare the frame seen on the tx node
  task automatic tx_chk(input logic [8:0] v, input logic [7:0] f);
    int nd;
    logic [10:0] e;
    nd = f[4] ? 9 : 8;
    e = {2'h0, v & (f[4] ? 9'h1FF : 9'h0FF)};
    if (f[1]) e[nd] = ^e ^ f[0];
    e[nd + f[1]] = 1'b1;
    fork
      wr(6'h1C, v);
      u_remote.grab(nd + f[1] + 1, 16, cap);
    join
    `chk(cap, e)
  endtask

  // Line must stay high for a while
  task automatic quiet;
    bad = 1'b0;
    repeat (200) @(posedge ref_clk) bad |= (node !== 1'b1);
  endtask

  task automatic t_reset;
    rd(6'h04, 9'h004, 2'h0);
    rd(6'h10, 9'h000, 2'h0);
    rd(6'h08, 9'h000, 2'h0);
    rd(6'h3C, 9'h000, ubc_pkg::RESP_SLVERR);
    $display("test reset done");
  endtask

  task automatic t_div;
    wr(6'h04, 9'h001);
    rd(6'h04, 9'h001, 2'h0);
    wr(6'h0C, 9'h008);
    rd(6'h10, 9'h001, 2'h0);
    wr(6'h04, 9'h005);
    wr(6'h00, 9'h001);
    rd(6'h04, 9'h001, 2'h0);
    rd(6'h00, 9'h000, 2'h0);
    wr(6'h0C, 9'h000);
    wr(6'h04, 9'h000);
    wr(6'h0C, 9'h008);
    wr(6'h1C, 9'h055);
    quiet();
    `chk(bad, 1'b0)
    wr(6'h0C, 9'h000);
    wr(6'h04, 9'h001);
    wr(6'h08, 9'h040);
    wait_mode <= 1'b1;
    wr(6'h0C, 9'h008);
    quiet();
    `chk(bad, 1'b0)
    fork
      wait_mode <= 1'b0;
      u_remote.grab(9, 16, cap);
    join
    `chk(cap, 11'h155)
    $display("test divisor done");
  endtask

  task automatic t_frames;
    logic [7:0] m [4] = '{8'h00, 8'h02, 8'h03, 8'h13};
    foreach (m[i]) begin
      wr(6'h0C, 9'h000);
      wr(6'h08, {1'b0, m[i]});
      wr(6'h0C, 9'h008);
      // Drive flag follows the enable one clock later
      @(negedge ref_clk);
      `chk(txe, 1'b1)
      tx_chk(9'h1A5, m[i]);
    end
    fork
      wr(6'h1C, 9'h0F0);
      @(negedge txo) wr(6'h0C, 9'h000);
    join
    `chk(txe, 1'b1)
    repeat (200) @(posedge ref_clk);
    `chk(txe, 1'b0)
    $display("test frames done");
  endtask

  task automatic t_rx;
    wr(6'h08, 9'h000);
    wr(6'h0C, 9'h004);
    u_remote.send(10'h03C, 8, 16);
    rd(6'h1C, 9'h03C, 2'h0);
    // Line high long enough after the character sets the idle flag
    repeat (200) @(posedge ref_clk);
    rd(6'h10, 9'h041, 2'h0);
    rx_gate <= 1'b0;
    wr(6'h0C, 9'h000);
    wr(6'h08, 9'h080);
    wr(6'h0C, 9'h00C);
    tx_chk(9'h05A, 8'h80);
    repeat (40) @(posedge ref_clk);
    rd(6'h1C, 9'h05A, 2'h0);
    wr(6'h0C, 9'h000);
    wr(6'h08, 9'h0A0);
    wr(6'h0C, 9'h00C);
    `chk(txe, 1'b0)
    u_remote.send(10'h096, 8, 16);
    rd(6'h1C, 9'h096, 2'h0);
    wr(6'h0C, 9'h02C);
    `chk(txe, 1'b1)
    $display("test routing done");
  endtask

  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_div();
    t_frames();
    t_rx();
    close_out();
  end

  // Watchdog, well beyond the expected run
  initial begin
    repeat (40000) @(posedge ref_clk);
    errors++;
    close_out();
  end
endmodule

/* File: tb/ubc_remote.sv */
// Purpose: remote serial device on the line side of the block
// Assumes: one stop bit, bit time given in clocks
// Notes: line idles high between frames
`timescale 1ns/1ps
module ubc_remote (
  // Line side
  input wire logic ref_clk,
  input wire logic tx_line,
  output logic rx_line
);
  // Idle level before the first frame
  initial rx_line = 1'b1;

  // Send start, data lsb first, stop
  task automatic send(input logic [9:0] v, input int nb, input int bt);
    for (int i = -1; i <= nb; i++) begin
      rx_line <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : v[i];
      repeat (bt) @(posedge ref_clk);
    end
  endtask

  // Capture bits after the start bit, sampled mid bit
  task automatic grab(input int nb, input int bt, output logic [10:0] v);
    v = '0;
    @(negedge tx_line);
    repeat (bt / 2) @(posedge ref_clk);
    for (int i = 0; i < nb; i++) begin
      repeat (bt) @(posedge ref_clk);
      v[i] = tx_line;
    end
  endtask
endmodule
